// ---- hdl/sys_event_pkg.sv ----
package sys_event_pkg;

    // Register offsets on the plain register port.
    localparam logic [15:0] USER_NMI_VEC_OFS = 16'h015A;
    localparam logic [15:0] SYS_NMI_VEC_OFS  = 16'h015C;
    localparam logic [15:0] RST_VEC_OFS      = 16'h015E;
    localparam logic [15:0] MBOX_OUT_OFS     = 16'h0160;
    localparam logic [15:0] MBOX_IN_OFS      = 16'h0162;
    localparam logic [15:0] MBOX_STAT_OFS    = 16'h0164;
    localparam logic [15:0] EVT_STATUS_OFS   = 16'h0166;
    localparam logic [15:0] EVT_MASK_OFS     = 16'h0168;

    // Flag positions; a flag at position i reports vector code 2*i.
    localparam int RST_SUPPLY_BROWNOUT = 1;
    localparam int RST_RESET_PIN       = 2;
    localparam int RST_SW_BROWNOUT     = 3;
    localparam int RST_SHUTDOWN_WAKE   = 4;
    localparam int RST_SECURITY        = 5;
    localparam int RST_SUPPLY_HIGH     = 7;
    localparam int RST_SW_POWER_ON     = 10;
    localparam int RST_WDOG_EXPIRY     = 11;
    localparam int RST_WDOG_PASSWORD   = 12;
    localparam int RST_NVM_PASSWORD    = 13;
    localparam int RST_NVM_UNCORRECT   = 14;
    localparam int RST_PERIPH_FETCH    = 15;
    localparam int RST_PMM_PASSWORD    = 16;
    localparam int RST_FREQ_LOCK_LOSS  = 18;

    localparam int SYS_LOW_POWER_ENTRY = 1;
    localparam int SYS_NVM_UNCORRECT   = 2;
    localparam int SYS_VACANT_ACCESS   = 9;
    localparam int SYS_MBOX_IN         = 10;
    localparam int SYS_MBOX_OUT        = 11;
    localparam int SYS_NVM_CORRECTED   = 12;

    localparam int USR_NMI_PIN         = 1;
    localparam int USR_OSC_FAULT       = 2;

    localparam logic [31:0] ONE = 32'h0000_0001;

    // Reset depth of each reset cause.
    localparam logic [31:0] BOR_LEVEL_MASK =
        (ONE << RST_SUPPLY_BROWNOUT) | (ONE << RST_RESET_PIN) |
        (ONE << RST_SW_BROWNOUT) | (ONE << RST_SHUTDOWN_WAKE) |
        (ONE << RST_SECURITY) | (ONE << RST_SUPPLY_HIGH);
    localparam logic [31:0] POR_LEVEL_MASK = ONE << RST_SW_POWER_ON;
    localparam logic [31:0] PUC_LEVEL_MASK =
        (ONE << RST_WDOG_EXPIRY) | (ONE << RST_WDOG_PASSWORD) |
        (ONE << RST_NVM_PASSWORD) | (ONE << RST_NVM_UNCORRECT) |
        (ONE << RST_PERIPH_FETCH) | (ONE << RST_PMM_PASSWORD) |
        (ONE << RST_FREQ_LOCK_LOSS);

    // Event status and mask bits.
    localparam int EVT_RESET_CAUSE = 0;
    localparam int EVT_SYSTEM_NMI  = 1;
    localparam int EVT_USER_NMI    = 2;
    localparam int EVT_WIDTH       = 3;

    localparam logic [15:0] VECTOR_EMPTY     = 16'h0000;
    localparam logic [31:0] FLAGS_RESET      = 32'h0000_0000;
    localparam logic [2:0]  EVT_RESET        = 3'h0;
    localparam logic [15:0] MBOX_DATA_RESET  = 16'h0000;
    localparam int          PIN_SYNC_STAGES  = 3;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } probe_req_t;

    typedef struct packed {
        logic supply_brownout;
        logic reset_pin;
        logic sw_brownout;
        logic shutdown_wake;
        logic security_violation;
        logic supply_high;
        logic sw_power_on;
        logic watchdog_expiry;
        logic watchdog_password;
        logic nvm_password;
        logic nvm_uncorrectable;
        logic periph_fetch;
        logic power_mgmt_password;
        logic freq_lock_loss;
        logic low_power_entry;
        logic vacant_access;
        logic nvm_corrected;
        logic oscillator_fault;
    } event_in_t;

    typedef struct packed {
        logic brownout_reset;
        logic power_on_reset;
        logic power_up_clear;
    } reset_req_t;

endpackage

// ---- hdl/system_event_vector_generator.sv ----
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Contract
// [RL1] Each vector reads 00h when idle, else code of lowest-coded pending event.
// [RL2] Every reset cause carries brownout, power-on or clear depth, requested on cause.
// [RL3] Reset vector: supply brownout 02h, reset pin 04h, soft brownout 06h, wake 08h.
// [RL4] Reset vector: security violation 0Ah, high supply event 0Eh; 0Ch, 10h reserved.
// [RL5] Reset vector: software power-on request 14h; 12h reserved.
// [RL6] Watchdog expiry 16h and watchdog password 18h cause power-up clear.
// [RL7] Memory controller password violation causes power-up clear, code 1Ah.
// [RL8] Uncorrectable memory error: 1Ch in reset vector, 04h in system vector.
// [RL9] Fetch from peripheral area causes power-up clear, code 1Eh.
// [RL10] Power password 20h and lock loss 24h at clear depth; rest reserved.
// [RL11] System vector: low-power reset entry 02h highest; 06h to 10h reserved.
// [RL12] Vacant memory access sets its flag, system code 12h.
// [RL13] Incoming mailbox data raises mailbox input event, system code 14h.
// [RL14] Outgoing mailbox data taken by probe raises output event, code 16h.
// [RL15] Corrected memory error reports system code 18h; 1Ah to 1Eh reserved.
// [RL16] User vector: nmi pin 02h highest, oscillator fault 04h; rest reserved.
// [RL17] Mailbox lets software and the debug probe exchange words.
// [RL18] Reading a vector clears the flag it reports.
// [RL19] Vectors are 16-bit, even codes only, writes ignored.
module system_event_vector_generator (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire sys_event_pkg::bus_req_t bus,
    output logic [15:0]                  rdata,
    input  wire sys_event_pkg::event_in_t events,
    input  wire logic                    nmi_pin,
    input  wire sys_event_pkg::probe_req_t probe,
    output logic [15:0]                  probe_rdata,
    output logic                         mbox_in_full,
    output logic                         mbox_out_full,
    output sys_event_pkg::reset_req_t    reset_req,
    output logic                         irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [15:0] vector_code(input logic [31:0] flags);
        logic [15:0] code;
        code = sys_event_pkg::VECTOR_EMPTY;
        for (int i = 31; i >= 1; i--) begin
            if (flags[i]) begin
                code = 16'(2 * i);
            end
        end
        return code;
    endfunction

    function automatic logic [31:0] lowest_flag(input logic [31:0] flags);
        return flags & (~flags + 32'h0000_0001);
    endfunction

    function automatic logic [31:0] bit_at(input logic on, input int pos);
        return on ? (sys_event_pkg::ONE << pos) : 32'h0000_0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser for the external non-maskable pin.

    logic [sys_event_pkg::PIN_SYNC_STAGES-1:0] nmi_sync;
    logic                                      nmi_level;
    logic                                      nmi_rise;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nmi_sync <= '0;
        end else begin
            nmi_sync <= {nmi_sync[1:0], nmi_pin};
        end
    end

    // A change counts once the second and third stages agree.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nmi_level <= 1'b0;
        end else if (nmi_sync[1] == nmi_sync[2]) begin
            nmi_level <= nmi_sync[2];
        end
    end

    assign nmi_rise = (nmi_sync[1] == nmi_sync[2]) && nmi_sync[2] &&
                      !nmi_level;

    ////////////////////////////////////////////////////////////////////////
    // Event set vectors.

    logic [31:0] rst_set;
    logic [31:0] sys_set;
    logic [31:0] usr_set;
    logic        mbox_in_evt;
    logic        mbox_out_evt;

    assign mbox_in_evt  = probe.wr;                       // see [RL13]
    assign mbox_out_evt = probe.rd && mbox_out_full;      // see [RL14]

    always_comb begin
        rst_set = bit_at(events.supply_brownout,
                         sys_event_pkg::RST_SUPPLY_BROWNOUT) |     // see [RL3]
                  bit_at(events.reset_pin,
                         sys_event_pkg::RST_RESET_PIN) |
                  bit_at(events.sw_brownout,
                         sys_event_pkg::RST_SW_BROWNOUT) |
                  bit_at(events.shutdown_wake,
                         sys_event_pkg::RST_SHUTDOWN_WAKE) |
                  bit_at(events.security_violation,
                         sys_event_pkg::RST_SECURITY) |            // see [RL4]
                  bit_at(events.supply_high,
                         sys_event_pkg::RST_SUPPLY_HIGH) |
                  bit_at(events.sw_power_on,
                         sys_event_pkg::RST_SW_POWER_ON) |         // see [RL5]
                  bit_at(events.watchdog_expiry,
                         sys_event_pkg::RST_WDOG_EXPIRY) |         // see [RL6]
                  bit_at(events.watchdog_password,
                         sys_event_pkg::RST_WDOG_PASSWORD) |
                  bit_at(events.nvm_password,
                         sys_event_pkg::RST_NVM_PASSWORD) |        // see [RL7]
                  bit_at(events.nvm_uncorrectable,
                         sys_event_pkg::RST_NVM_UNCORRECT) |       // see [RL8]
                  bit_at(events.periph_fetch,
                         sys_event_pkg::RST_PERIPH_FETCH) |        // see [RL9]
                  bit_at(events.power_mgmt_password,
                         sys_event_pkg::RST_PMM_PASSWORD) |        // see [RL10]
                  bit_at(events.freq_lock_loss,
                         sys_event_pkg::RST_FREQ_LOCK_LOSS);
        sys_set = bit_at(events.low_power_entry,
                         sys_event_pkg::SYS_LOW_POWER_ENTRY) |     // see [RL11]
                  bit_at(events.nvm_uncorrectable,
                         sys_event_pkg::SYS_NVM_UNCORRECT) |       // see [RL8]
                  bit_at(events.vacant_access,
                         sys_event_pkg::SYS_VACANT_ACCESS) |       // see [RL12]
                  bit_at(mbox_in_evt, sys_event_pkg::SYS_MBOX_IN) |
                  bit_at(mbox_out_evt, sys_event_pkg::SYS_MBOX_OUT) |
                  bit_at(events.nvm_corrected,
                         sys_event_pkg::SYS_NVM_CORRECTED);        // see [RL15]
        usr_set = bit_at(nmi_rise, sys_event_pkg::USR_NMI_PIN) |  // see [RL16]
                  bit_at(events.oscillator_fault,
                         sys_event_pkg::USR_OSC_FAULT);
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flags and vector reads.

    logic [31:0] rst_flags;
    logic [31:0] sys_flags;
    logic [31:0] usr_flags;
    logic        rd_rst_vec;
    logic        rd_sys_vec;
    logic        rd_usr_vec;

    assign rd_rst_vec = bus.rd && bus.addr == sys_event_pkg::RST_VEC_OFS;
    assign rd_sys_vec = bus.rd && bus.addr == sys_event_pkg::SYS_NMI_VEC_OFS;
    assign rd_usr_vec = bus.rd && bus.addr == sys_event_pkg::USER_NMI_VEC_OFS;

    // A read clears the reported flag, but a new set in the same cycle wins.
    // Writes never touch the flags.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rst_flags <= sys_event_pkg::FLAGS_RESET;
        end else begin
            rst_flags <= (rst_flags &
                          ~(rd_rst_vec ? lowest_flag(rst_flags) : '0)) |
                         rst_set;                          // see [RL18] [RL19]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sys_flags <= sys_event_pkg::FLAGS_RESET;
        end else begin
            sys_flags <= (sys_flags &
                          ~(rd_sys_vec ? lowest_flag(sys_flags) : '0)) |
                         sys_set;                          // see [RL18]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            usr_flags <= sys_event_pkg::FLAGS_RESET;
        end else begin
            usr_flags <= (usr_flags &
                          ~(rd_usr_vec ? lowest_flag(usr_flags) : '0)) |
                         usr_set;                          // see [RL18]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset depth requests; the deepest level wins.

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reset_req <= '0;
        end else begin
            reset_req.brownout_reset <=
                |(rst_set & sys_event_pkg::BOR_LEVEL_MASK);     // see [RL2]
            reset_req.power_on_reset <=
                |(rst_set & sys_event_pkg::POR_LEVEL_MASK) &&
                !(|(rst_set & sys_event_pkg::BOR_LEVEL_MASK));
            reset_req.power_up_clear <=
                |(rst_set & sys_event_pkg::PUC_LEVEL_MASK) &&
                !(|(rst_set & (sys_event_pkg::BOR_LEVEL_MASK |
                               sys_event_pkg::POR_LEVEL_MASK)));  // see [RL6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug mailbox.

    logic [15:0] mbox_in_data;
    logic        wr_mbox_out;
    logic        rd_mbox_in;

    assign wr_mbox_out = bus.wr && bus.addr == sys_event_pkg::MBOX_OUT_OFS;
    assign rd_mbox_in  = bus.rd && bus.addr == sys_event_pkg::MBOX_IN_OFS;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mbox_in_data <= sys_event_pkg::MBOX_DATA_RESET;
            mbox_in_full <= 1'b0;
        end else begin
            if (probe.wr) begin
                mbox_in_data <= probe.wdata;               // see [RL17]
            end
            mbox_in_full <= probe.wr || (mbox_in_full && !rd_mbox_in);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            probe_rdata   <= sys_event_pkg::MBOX_DATA_RESET;
            mbox_out_full <= 1'b0;
        end else begin
            if (wr_mbox_out) begin
                probe_rdata <= bus.wdata;                  // see [RL17]
            end
            mbox_out_full <= wr_mbox_out || (mbox_out_full && !probe.rd);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status, mask and interrupt.

    logic [sys_event_pkg::EVT_WIDTH-1:0] evt_status;
    logic [sys_event_pkg::EVT_WIDTH-1:0] evt_mask;
    logic [sys_event_pkg::EVT_WIDTH-1:0] evt_set;
    logic                                wr_status;

    assign evt_set   = {|usr_set, |sys_set, |rst_set};
    assign wr_status = bus.wr && bus.addr == sys_event_pkg::EVT_STATUS_OFS;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_status <= sys_event_pkg::EVT_RESET;
        end else begin
            evt_status <= (evt_status &
                           ~(wr_status ? bus.wdata[2:0] : 3'h0)) | evt_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_mask <= sys_event_pkg::EVT_RESET;
        end else if (bus.wr && bus.addr == sys_event_pkg::EVT_MASK_OFS) begin
            evt_mask <= bus.wdata[2:0];
        end
    end

    assign irq = |(evt_status & evt_mask);

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the read strobe.

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= sys_event_pkg::VECTOR_EMPTY;
        end else if (bus.rd) begin
            unique case (bus.addr)
                sys_event_pkg::RST_VEC_OFS:
                    rdata <= vector_code(rst_flags);       // see [RL1]
                sys_event_pkg::SYS_NMI_VEC_OFS:
                    rdata <= vector_code(sys_flags);
                sys_event_pkg::USER_NMI_VEC_OFS:
                    rdata <= vector_code(usr_flags);
                sys_event_pkg::MBOX_OUT_OFS:  rdata <= probe_rdata;
                sys_event_pkg::MBOX_IN_OFS:   rdata <= mbox_in_data;
                sys_event_pkg::MBOX_STAT_OFS:
                    rdata <= {14'h0000, mbox_out_full, mbox_in_full};
                sys_event_pkg::EVT_STATUS_OFS: rdata <= {13'h0000, evt_status};
                sys_event_pkg::EVT_MASK_OFS:   rdata <= {13'h0000, evt_mask};
                default: rdata <= sys_event_pkg::VECTOR_EMPTY;
            endcase
        end else begin
            rdata <= sys_event_pkg::VECTOR_EMPTY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking check_clk @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_probe_write;
        probe.wr;
    endsequence

    sequence s_probe_take;
        probe.rd && mbox_out_full && !wr_mbox_out;
    endsequence

    a_vec_idle_zero: assert property ( // see [RL1]
        rd_rst_vec && rst_flags == 32'h0 |=> rdata == 16'h0000)
        else $error("reset vector not zero when idle");

    a_rst_top_code: assert property ( // see [RL3]
        rd_rst_vec && rst_flags[1] |=> rdata == 16'h0002)
        else $error("supply brownout not reported as top code");

    a_bor_depth: assert property ( // see [RL2]
        events.reset_pin |=> reset_req.brownout_reset &&
        !reset_req.power_up_clear)
        else $error("reset pin did not request brownout depth");

    a_wdog_clear: assert property ( // see [RL6]
        events.watchdog_expiry &&
        !(|(rst_set & (sys_event_pkg::BOR_LEVEL_MASK |
                       sys_event_pkg::POR_LEVEL_MASK)))
        |=> reset_req.power_up_clear && !reset_req.brownout_reset &&
            !reset_req.power_on_reset)
        else $error("watchdog expiry did not request power-up clear");

    a_por_depth: assert property ( // see [RL5]
        rst_set == (sys_event_pkg::ONE << sys_event_pkg::RST_SW_POWER_ON)
        |=> reset_req.power_on_reset)
        else $error("software power-on request lost its depth");

    a_read_clear: assert property ( // see [RL18]
        rd_sys_vec && sys_flags[1] && !sys_set[1] |=> !sys_flags[1])
        else $error("vector read did not clear reported flag");

    a_write_ignored: assert property ( // see [RL19]
        bus.wr && bus.addr == sys_event_pkg::RST_VEC_OFS && !bus.rd &&
        rst_set == 32'h0 |=> rst_flags == $past(rst_flags))
        else $error("write changed reset vector flags");

    a_mbox_in_evt: assert property ( // see [RL13]
        s_probe_write |=> sys_flags[sys_event_pkg::SYS_MBOX_IN] &&
        mbox_in_full)
        else $error("mailbox input event missing");

    a_mbox_out_evt: assert property ( // see [RL14]
        s_probe_take |=> sys_flags[sys_event_pkg::SYS_MBOX_OUT] &&
        !mbox_out_full)
        else $error("mailbox output event missing");

    a_vacant_code: assert property ( // see [RL12]
        rd_sys_vec && sys_flags[9:1] == 9'h100 |=> rdata == 16'h0012)
        else $error("vacant access not reported as 12h");

    a_nmi_pin_evt: assert property ( // see [RL16]
        $rose(nmi_pin) ##1 nmi_pin [*3] |-> ##[1:2] usr_flags[1])
        else $error("nmi pin edge not flagged in time");

endmodule

// ---- testbench/core_model.sv ----
`timescale 1ns/1ps
module core_model (
    input  wire logic                 ref_clk,
    input  wire logic [15:0]          rdata,
    output sys_event_pkg::bus_req_t   bus
);
    initial begin
        bus = '0;
    end

    // Each strobe is high for one cycle; read data is taken the cycle after.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule

// ---- testbench/system_event_vector_generator_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    failures++; $display("mismatch %s exp %h got %h", n, e, s); end end
module system_event_vector_generator_test;
    localparam logic [15:0] UV = sys_event_pkg::USER_NMI_VEC_OFS;
    localparam logic [15:0] SV = sys_event_pkg::SYS_NMI_VEC_OFS;
    localparam logic [15:0] RV = sys_event_pkg::RST_VEC_OFS;
    logic                       ref_clk = 1'b0;
    logic                       rst = 1'b1;
    sys_event_pkg::bus_req_t    bus;
    logic [15:0]                rdata;
    sys_event_pkg::event_in_t   events = '0;
    sys_event_pkg::event_in_t   e;
    logic                       nmi_pin = 1'b0;
    sys_event_pkg::probe_req_t  probe = '0;
    logic [15:0]                probe_rdata;
    logic                       mbox_in_full;
    logic                       mbox_out_full;
    sys_event_pkg::reset_req_t  reset_req;
    logic                       irq;
    logic [15:0]                d;
    int                         failures = 0;
    int                         comparisons = 0;

    system_event_vector_generator dut (
        .ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .events(events), .nmi_pin(nmi_pin), .probe(probe),
        .probe_rdata(probe_rdata), .mbox_in_full(mbox_in_full),
        .mbox_out_full(mbox_out_full), .reset_req(reset_req), .irq(irq)
    );
    core_model core (.ref_clk(ref_clk), .rdata(rdata), .bus(bus));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic pulse(input sys_event_pkg::event_in_t v);
        @(posedge ref_clk);
        events <= v;
        @(posedge ref_clk);
        events <= '0;
        #1;
    endtask

    task automatic drain(input logic [15:0] a, input logic [7:0] q[$]);
        logic [15:0] v;
        foreach (q[i]) begin
            core.rd(a, v);
            `CHK("vector", {8'h00, q[i]}, v)
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_idle();
        drain(RV, '{8'h00});
        drain(SV, '{8'h00});
        drain(UV, '{8'h00});
        core.wr(RV, 16'h0014);
        drain(RV, '{8'h00});
        core.rd(16'h0170, d);
        `CHK("unmapped", 16'h0000, d)
    endtask

    task automatic t_depth();
        e = '0;
        e.watchdog_expiry = 1'b1;
        pulse(e);
        `CHK("reset_req", 3'b001, reset_req)
        e = '0;
        e.sw_power_on = 1'b1;
        pulse(e);
        `CHK("reset_req", 3'b010, reset_req)
        e = '0;
        e.supply_brownout = 1'b1;
        pulse(e);
        `CHK("reset_req", 3'b100, reset_req)
        drain(RV, '{8'h02, 8'h14, 8'h16, 8'h00});
    endtask

    task automatic t_reset_order();
        e = '0;
        {e.supply_brownout, e.reset_pin, e.sw_brownout, e.shutdown_wake,
         e.security_violation, e.supply_high, e.sw_power_on,
         e.watchdog_expiry, e.watchdog_password, e.nvm_password,
         e.nvm_uncorrectable, e.periph_fetch, e.power_mgmt_password,
         e.freq_lock_loss} = 14'h3FFF;
        pulse(e);
        `CHK("reset_req", 3'b100, reset_req)
        drain(RV, '{8'h02, 8'h04, 8'h06, 8'h08});
        drain(RV, '{8'h0A, 8'h0E});
        drain(RV, '{8'h14, 8'h16, 8'h18, 8'h1A});
        drain(RV, '{8'h1C});
        drain(RV, '{8'h1E, 8'h20, 8'h24, 8'h00});
        drain(SV, '{8'h04, 8'h00});
    endtask

    task automatic t_system();
        @(posedge ref_clk);
        probe <= '{wr: 1'b1, rd: 1'b0, wdata: 16'hA5C3};
        @(posedge ref_clk);
        probe <= '0;
        #1 `CHK("in_full", 1'b1, mbox_in_full)
        core.rd(sys_event_pkg::MBOX_IN_OFS, d);
        `CHK("mbox_in", 16'hA5C3, d)
        `CHK("in_full", 1'b0, mbox_in_full)
        core.wr(sys_event_pkg::MBOX_OUT_OFS, 16'h3C5A);
        #1 `CHK("probe_rdata", 16'h3C5A, probe_rdata)
        `CHK("out_full", 1'b1, mbox_out_full)
        core.rd(sys_event_pkg::MBOX_STAT_OFS, d);
        `CHK("mbox_stat", 16'h0002, d)
        e = '0;
        {e.low_power_entry, e.vacant_access, e.nvm_corrected} = 3'h7;
        @(posedge ref_clk);
        probe  <= '{wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        events <= e;
        @(posedge ref_clk);
        probe  <= '0;
        events <= '0;
        #1 `CHK("out_full", 1'b0, mbox_out_full)
        drain(SV, '{8'h02, 8'h12});
        drain(SV, '{8'h14, 8'h16});
        drain(SV, '{8'h18, 8'h00});
    endtask

    // Flags taken before a mid-run reset must be gone after it.
    task automatic t_reset();
        e = '0;
        e.nvm_corrected = 1'b1;
        pulse(e);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        drain(SV, '{8'h00});
    endtask

    task automatic t_user();
        @(posedge ref_clk);
        nmi_pin <= 1'b1;
        e = '0;
        e.oscillator_fault = 1'b1;
        pulse(e);
        repeat (5) @(posedge ref_clk);
        nmi_pin <= 1'b0;
        drain(UV, '{8'h02, 8'h04, 8'h00});
    endtask

    task automatic t_irq();
        core.wr(sys_event_pkg::EVT_STATUS_OFS, 16'h0007);
        core.wr(sys_event_pkg::EVT_MASK_OFS, 16'h0002);
        #1 `CHK("irq", 1'b0, irq)
        e = '0;
        e.oscillator_fault = 1'b1;
        pulse(e);
        `CHK("irq", 1'b0, irq)
        e = '0;
        e.vacant_access = 1'b1;
        pulse(e);
        `CHK("irq", 1'b1, irq)
        core.rd(sys_event_pkg::EVT_STATUS_OFS, d);
        `CHK("status", 16'h0006, d)
        core.wr(sys_event_pkg::EVT_STATUS_OFS, 16'h0002);
        #1 `CHK("irq", 1'b0, irq)
        drain(SV, '{8'h12, 8'h00});
        drain(UV, '{8'h04, 8'h00});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_idle();
        t_depth();
        t_reset_order();
        t_system();
        t_user();
        t_reset();
        t_irq();
        end_of_test();
    end

    initial begin
        #2ms;
        failures++;
        end_of_test();
    end
endmodule
